// [design/mains_loss_overload_supervisor.sv]
// command source, mains loss handling and inverse time overload trip
// Contract
// - negative setpoint runs backward, positive runs forward
// - setpoint from sections, link or panel
// - instant trip option stops drive, reports not ready
// - restart only inside window without stop
// - 100 s window means never restart
// - ride through lowers output frequency gradually
// - ride through ends at time limit or stop
// - ready drive: short outage ready, long not ready
// - running drive: short outage restarts or goes ready
// - overload arms above rated, heavier trips sooner
// - trip times follow the overload table
`timescale 1ns/1ps
`default_nettype none
module mains_loss_overload_supervisor #(
  parameter int tick_cycles = supervisor_pkg::TICK_CYCLES   // shorten for simulation
) (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        mains_ok,        // pin, mains present
  input  wire logic                        di_start,        // pin, start pulse
  input  wire logic                        di_stop,         // pin, stop pulse
  input  wire logic                        di_run,          // pin, level mode run
  input  wire supervisor_pkg::cmd_src_type cmd_src,
  input  wire logic                        di_pulse_mode,   // 1 pulse, 0 level
  input  wire supervisor_pkg::sp_src_type  sp_src,
  input  wire logic                        reverse_release,
  input  wire logic                        panel_start,     // one cycle pulses
  input  wire logic                        panel_stop,
  input  wire logic                        link_start,
  input  wire logic                        link_stop,
  input  wire logic signed [15:0]          sp_sections,
  input  wire logic signed [15:0]          sp_link,
  input  wire logic signed [15:0]          sp_panel,
  input  wire logic                        instant_trip_on_mains_loss,
  input  wire logic                        auto_restart,
  input  wire logic                        ride_through,
  input  wire logic [6:0]                  restart_window,  // seconds
  input  wire logic [6:0]                  ride_max,        // seconds
  input  wire logic [7:0]                  current_pct,     // percent of rated
  input  wire logic                        fault_ack,       // one cycle pulse
  output logic                             run_cmd,
  output logic                             reverse,
  output logic signed [15:0]               freq_cmd,
  output logic                             ready,
  output logic                             mains_not_ready,
  output logic                             mains_loss,
  output logic                             ride_active,
  output logic                             overload_trip
);
  // whole state of the block, registered in one place
  typedef struct packed {
    logic [2:0]                    mains_sync;      // three stage pin sampler
    logic [2:0]                    start_sync;
    logic [2:0]                    stop_sync;
    logic [2:0]                    run_sync;
    logic                          mains_level;     // filtered pin levels
    logic                          start_level;
    logic                          stop_level;
    logic                          run_level;
    logic                          start_prev;      // edge detector memory
    logic                          stop_prev;
    logic                          run_prev;
    logic [23:0]                   tick_cnt;        // divider towards the timer tick
    logic                          tick;            // one cycle enable, 100 ms apart
    supervisor_pkg::sup_state_type state;
    logic [10:0]                   outage_ticks;    // outage duration so far
    logic [10:0]                   ride_ticks;      // ride through time so far
    logic [11:0]                   ol_ticks;        // overload time so far
    logic                          stop_seen;       // stop came during an outage
    logic                          run_cmd;
    logic                          reverse;
    logic signed [15:0]            freq_cmd;
    logic                          ready;
    logic                          mains_not_ready;
    logic                          mains_loss;
    logic                          ride_active;
    logic                          overload_trip;
  } sup_regs_type;

  sup_regs_type       st;                 // registered state
  sup_regs_type       next_st;            // next value of the state
  logic               start_evt;          // start command this cycle
  logic               stop_evt;           // stop command this cycle
  logic               mains_down;         // filtered mains absent
  logic               ol_expired;         // overload time used up
  logic signed [15:0] selected_sp;        // setpoint of the chosen source
  logic [10:0]        window_ticks;       // permitted outage, in ticks
  logic [10:0]        ride_limit_ticks;   // permitted ride through, in ticks

  // a change counts once the second and third stage agree
  function automatic logic filtered(input logic [2:0] s, input logic old);
    filtered = (s[1] == s[2]) ? s[2] : old;
  endfunction

  // seconds to timer ticks, the window fits eleven bits
  function automatic logic [10:0] secs_to_ticks(input logic [6:0] s);
    secs_to_ticks = 11'(int'(s) * supervisor_pkg::TICKS_PER_S);
  endfunction

  // inverse time: heavier overload gives a shorter limit
  function automatic logic [11:0] overload_limit(input logic [7:0] pct);
    int secs;
    if (pct >= supervisor_pkg::OL_P200) begin
      secs = supervisor_pkg::OL_T200_S;
    end else if (pct >= supervisor_pkg::OL_P150) begin
      secs = supervisor_pkg::OL_T150_S;
    end else if (pct >= supervisor_pkg::OL_P140) begin
      secs = supervisor_pkg::OL_T140_S;
    end else if (pct >= supervisor_pkg::OL_P130) begin
      secs = supervisor_pkg::OL_T130_S;
    end else if (pct >= supervisor_pkg::OL_P120) begin
      secs = supervisor_pkg::OL_T120_S;
    end else begin
      secs = supervisor_pkg::OL_T110_S;        // anything above rated up to 120 %
    end
    overload_limit = 12'(secs * supervisor_pkg::TICKS_PER_S);
  endfunction

  // one ride step towards standstill, never overshooting zero
  function automatic logic signed [15:0] step_toward_zero(input logic signed [15:0] f);
    logic signed [15:0] step;
    step = $signed(supervisor_pkg::RIDE_STEP);
    if (f > step) begin
      step_toward_zero = f - step;
    end else if (f < -step) begin
      step_toward_zero = f + step;
    end else begin
      step_toward_zero = 16'h0000;
    end
  endfunction

  // size of a signed frequency
  function automatic logic [15:0] magnitude(input logic signed [15:0] f);
    magnitude = f[15] ? 16'(-f) : 16'(f);
  endfunction

  assign mains_down       = ~st.mains_level;
  assign window_ticks     = secs_to_ticks(restart_window);
  assign ride_limit_ticks = secs_to_ticks(ride_max);
  // no thermal memory: the count restarts once current is back at rated
  assign ol_expired       = (current_pct > supervisor_pkg::RATED_PCT) &&
                            (st.ol_ticks >= overload_limit(current_pct));

  // start and stop from the configured command source
  always_comb begin
    start_evt = 1'b0;
    stop_evt  = 1'b0;
    unique case (cmd_src)
      supervisor_pkg::SRC_PANEL: begin
        start_evt = panel_start;
        stop_evt  = panel_stop;
      end
      supervisor_pkg::SRC_LINK: begin
        start_evt = link_start;
        stop_evt  = link_stop;
      end
      supervisor_pkg::SRC_DIGITAL: begin
        if (di_pulse_mode) begin
          start_evt = st.start_level & ~st.start_prev;
          stop_evt  = st.stop_level & ~st.stop_prev;
        end else begin
          start_evt = st.run_level & ~st.run_prev;
          stop_evt  = ~st.run_level & st.run_prev;
        end
      end
      default: begin                                               // unused code, no command
        start_evt = 1'b0;
        stop_evt  = 1'b0;
      end
    endcase
  end

  // setpoint from sections, link or panel
  always_comb begin
    unique case (sp_src)
      supervisor_pkg::SP_SECTIONS: selected_sp = sp_sections;
      supervisor_pkg::SP_LINK:     selected_sp = sp_link;
      supervisor_pkg::SP_PANEL:    selected_sp = sp_panel;
      default:                     selected_sp = 16'h0000;        // unused code, stand still
    endcase
  end

  // next state: samplers, tick, timers and the supervisor itself
  always_comb begin
    next_st = st;
    // pins pass three flip-flops before use
    next_st.mains_sync  = {st.mains_sync[1:0], mains_ok};
    next_st.start_sync  = {st.start_sync[1:0], di_start};
    next_st.stop_sync   = {st.stop_sync[1:0], di_stop};
    next_st.run_sync    = {st.run_sync[1:0], di_run};
    next_st.mains_level = filtered(st.mains_sync, st.mains_level);
    next_st.start_level = filtered(st.start_sync, st.start_level);
    next_st.stop_level  = filtered(st.stop_sync, st.stop_level);
    next_st.run_level   = filtered(st.run_sync, st.run_level);
    next_st.start_prev  = st.start_level;
    next_st.stop_prev   = st.stop_level;
    next_st.run_prev    = st.run_level;
    // fixed tick from the clock keeps every duration deterministic
    next_st.tick     = (st.tick_cnt == 24'(tick_cycles - 1));
    next_st.tick_cnt = next_st.tick ? 24'h000000 : st.tick_cnt + 24'h000001;
    // overload time, saturating so it cannot wrap back below a limit
    if (current_pct > supervisor_pkg::RATED_PCT) begin
      if (st.tick && (st.ol_ticks != 12'hfff)) begin
        next_st.ol_ticks = st.ol_ticks + 12'h001;
      end
    end else begin
      next_st.ol_ticks = 12'h000;
    end
    // acknowledge clears the loss flag; a new loss below wins
    if (fault_ack) begin
      next_st.mains_loss = 1'b0;
    end
    if (ol_expired && (st.state != supervisor_pkg::ST_TRIP)) begin
      next_st.state = supervisor_pkg::ST_TRIP;
    end else begin
      unique case (st.state)
        supervisor_pkg::ST_READY: begin
          if (mains_down) begin
            if (instant_trip_on_mains_loss) begin
              next_st.state = supervisor_pkg::ST_NOT_READY;
            end else begin
              next_st.state        = supervisor_pkg::ST_OUT_READY;
              next_st.outage_ticks = 11'h000;
            end
          end else if (start_evt) begin
            next_st.state = supervisor_pkg::ST_RUN;
          end
        end
        supervisor_pkg::ST_RUN: begin
          if (mains_down) begin
            if (instant_trip_on_mains_loss) begin
              next_st.state = supervisor_pkg::ST_NOT_READY;
            end else if (ride_through) begin
              next_st.state      = supervisor_pkg::ST_RIDE;
              next_st.ride_ticks = 11'h000;
            end else begin
              next_st.state        = supervisor_pkg::ST_OUT_RUN;
              next_st.outage_ticks = 11'h000;
              next_st.stop_seen    = 1'b0;
            end
          end else if (stop_evt) begin
            next_st.state = supervisor_pkg::ST_READY;
          end
        end
        supervisor_pkg::ST_OUT_READY: begin
          if (!mains_down) begin
            next_st.state = supervisor_pkg::ST_READY;
          end else if (st.outage_ticks >= window_ticks) begin
            next_st.state      = supervisor_pkg::ST_NOT_READY;
            next_st.mains_loss = 1'b1;
          end else if (st.tick) begin
            next_st.outage_ticks = st.outage_ticks + 11'h001;
          end
        end
        supervisor_pkg::ST_OUT_RUN: begin
          if (stop_evt) begin
            next_st.stop_seen = 1'b1;
          end
          if (!mains_down) begin
            // the 100 s setting forbids restart outright
            if (auto_restart && !st.stop_seen && !stop_evt &&
                (restart_window != supervisor_pkg::NEVER_RESTART_S)) begin
              next_st.state = supervisor_pkg::ST_RUN;
            end else begin
              next_st.state = supervisor_pkg::ST_READY;
            end
          end else if (st.outage_ticks >= window_ticks) begin
            next_st.state      = supervisor_pkg::ST_NOT_READY;
            next_st.mains_loss = 1'b1;
          end else if (st.tick) begin
            next_st.outage_ticks = st.outage_ticks + 11'h001;
          end
        end
        supervisor_pkg::ST_RIDE: begin
          if (stop_evt) begin
            next_st.state = supervisor_pkg::ST_READY;
          end else if (!mains_down) begin
            next_st.state = supervisor_pkg::ST_RUN;
          end else if (st.ride_ticks >= ride_limit_ticks) begin
            next_st.state      = supervisor_pkg::ST_NOT_READY;
            next_st.mains_loss = 1'b1;
          end else if (st.tick) begin
            next_st.ride_ticks = st.ride_ticks + 11'h001;
            next_st.freq_cmd   = step_toward_zero(st.freq_cmd);
          end
        end
        supervisor_pkg::ST_NOT_READY: begin
          if (!mains_down) begin
            next_st.state = supervisor_pkg::ST_READY;
          end
        end
        supervisor_pkg::ST_TRIP: begin
          if (fault_ack) begin
            next_st.state = supervisor_pkg::ST_READY;
          end
        end
      endcase
    end
    // outputs follow the state they belong to
    next_st.ready           = (next_st.state == supervisor_pkg::ST_READY);
    next_st.mains_not_ready = (next_st.state == supervisor_pkg::ST_NOT_READY);
    next_st.ride_active     = (next_st.state == supervisor_pkg::ST_RIDE);
    next_st.overload_trip   = (next_st.state == supervisor_pkg::ST_TRIP);
    next_st.run_cmd         = (next_st.state == supervisor_pkg::ST_RUN) ||
                              (next_st.state == supervisor_pkg::ST_RIDE);
    if (next_st.state == supervisor_pkg::ST_RUN) begin
      // without the release a negative setpoint only stops the motor
      next_st.reverse  = reverse_release && selected_sp[15];
      next_st.freq_cmd = (reverse_release || !selected_sp[15]) ? selected_sp : 16'h0000;
    end else if (next_st.state != supervisor_pkg::ST_RIDE) begin
      next_st.reverse  = 1'b0;
      next_st.freq_cmd = supervisor_pkg::FREQ_RESET;
    end
  end

  // state register with synchronous reset, idle pin levels preloaded
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st             <= '0;
      st.mains_sync  <= 3'h7;           // mains idles present, no false loss
      st.mains_level <= 1'b1;
      st.state       <= supervisor_pkg::ST_READY;
      st.ready       <= 1'b1;
      st.freq_cmd    <= supervisor_pkg::FREQ_RESET;
    end else begin
      st <= next_st;
    end
  end

  // every output straight from the register
  assign run_cmd         = st.run_cmd;
  assign reverse         = st.reverse;
  assign freq_cmd        = st.freq_cmd;
  assign ready           = st.ready;
  assign mains_not_ready = st.mains_not_ready;
  assign mains_loss      = st.mains_loss;
  assign ride_active     = st.ride_active;
  assign overload_trip   = st.overload_trip;

  // checks, all on the one clock
  default clocking chk_cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  reverse_sign_a: assert property (
    (next_st.state == supervisor_pkg::ST_RUN) && reverse_release |=> reverse == $past(selected_sp[15]))
    else $error("reverse does not follow setpoint sign");
  setpoint_source_a: assert property (
    (next_st.state == supervisor_pkg::ST_RUN) && reverse_release |=> freq_cmd == $past(selected_sp))
    else $error("frequency does not follow selected setpoint");
  instant_trip_a: assert property (
    ((st.state == supervisor_pkg::ST_READY) || (st.state == supervisor_pkg::ST_RUN)) &&
    instant_trip_on_mains_loss && mains_down && !ol_expired
    |=> (st.state == supervisor_pkg::ST_NOT_READY) && mains_not_ready && !run_cmd)
    else $error("mains loss did not trip at once");
  never_restart_a: assert property (
    (st.state == supervisor_pkg::ST_OUT_RUN) && (restart_window == supervisor_pkg::NEVER_RESTART_S)
    |=> st.state != supervisor_pkg::ST_RUN)
    else $error("restart with the never restart window");
  ride_slowing_a: assert property (
    (st.state == supervisor_pkg::ST_RIDE) && (next_st.state == supervisor_pkg::ST_RIDE)
    |=> magnitude(freq_cmd) <= $past(magnitude(freq_cmd)))
    else $error("ride through raised the frequency");
  ride_stop_a: assert property (
    (st.state == supervisor_pkg::ST_RIDE) && stop_evt && !ol_expired |=> !ride_active && !run_cmd)
    else $error("ride through ignored a stop");
  window_expiry_a: assert property (
    (st.state == supervisor_pkg::ST_OUT_READY) && mains_down && !ol_expired &&
    (st.outage_ticks >= window_ticks) |=> mains_not_ready && mains_loss)
    else $error("long outage did not flag mains loss");
  no_arm_a: assert property (
    current_pct <= supervisor_pkg::RATED_PCT |=> st.ol_ticks == 12'h000)
    else $error("overload armed at rated current");
  overload_trip_a: assert property (
    ol_expired && (st.state != supervisor_pkg::ST_TRIP) |=> overload_trip && !run_cmd)
    else $error("overload limit passed without trip");

  // main scenarios worth seeing
  ride_seen_c:    cover property (st.state == supervisor_pkg::ST_RIDE);
  restart_seen_c: cover property (st.state == supervisor_pkg::ST_OUT_RUN ##1 st.state == supervisor_pkg::ST_RUN);
  trip_seen_c:    cover property (st.state == supervisor_pkg::ST_TRIP);
  lost_seen_c:    cover property (st.state == supervisor_pkg::ST_NOT_READY);
endmodule
`default_nettype wire

// [design/supervisor_pkg.sv]
// constants and types shared by the mains loss and overload supervisor
package supervisor_pkg;
  // clock and supervisory tick
  localparam int CLK_PERIOD_NS = 100;                       // 10 mhz system clock
  localparam int TICK_NS       = 100_000_000;               // 100 ms timer tick
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;   // cycles per tick
  localparam int TICKS_PER_S   = 1_000_000_000 / TICK_NS;   // ticks per second
  // outage window value that forbids any restart
  localparam logic [6:0] NEVER_RESTART_S = 7'h64;           // 100 s
  // rated current in percent of motor rating
  localparam logic [7:0] RATED_PCT = 8'h64;                 // 100 %
  // overload bands, percent of rated current
  localparam logic [7:0] OL_P120 = 8'h78;
  localparam logic [7:0] OL_P130 = 8'h82;
  localparam logic [7:0] OL_P140 = 8'h8c;
  localparam logic [7:0] OL_P150 = 8'h96;
  localparam logic [7:0] OL_P200 = 8'hc8;
  // longest permitted overload per band, seconds
  localparam int OL_T110_S = 251;
  localparam int OL_T120_S = 120;
  localparam int OL_T130_S = 76;
  localparam int OL_T140_S = 55;
  localparam int OL_T150_S = 42;
  localparam int OL_T200_S = 18;
  // output frequency drop per tick while riding through
  localparam logic [15:0] RIDE_STEP = 16'h0005;
  // reset values
  localparam logic [15:0] FREQ_RESET = 16'h0000;
  // command source and setpoint source
  typedef enum logic [1:0] {SRC_PANEL, SRC_LINK, SRC_DIGITAL} cmd_src_type;
  typedef enum logic [1:0] {SP_SECTIONS, SP_LINK, SP_PANEL} sp_src_type;
  // supervisor states
  typedef enum logic [2:0] {
    ST_READY, ST_RUN, ST_OUT_READY, ST_OUT_RUN, ST_RIDE, ST_NOT_READY, ST_TRIP
  } sup_state_type;
endpackage

// [verification/plant_side.sv]
// plant side model: turns a bench request into a start or stop pulse on the digital input
`timescale 1ns/1ps
`default_nettype none
module plant_side (
  input  wire logic clk,
  input  wire logic start_req,
  input  wire logic stop_req,
  output logic      di_start,
  output logic      di_stop
);
  // pulses three clocks wide, so the pin filter sees two agreeing samples
  logic [1:0] start_left = 2'h0, stop_left = 2'h0;
  always_ff @(posedge clk) begin
    start_left <= start_req ? 2'h3 : (start_left != 2'h0) ? start_left - 2'h1 : 2'h0;
    stop_left  <= stop_req ? 2'h3 : (stop_left != 2'h0) ? stop_left - 2'h1 : 2'h0;
  end
  assign di_start = (start_left != 2'h0);
  assign di_stop  = (stop_left != 2'h0);
endmodule
`default_nettype wire

// [verification/test_mains_loss_overload_supervisor.sv]
// supervisor bench: random setpoints per source, then instant trip on mains loss
`timescale 1ns/1ps
`default_nettype none
module test_mains_loss_overload_supervisor;
  logic clk = 0, rst_n = 0, mains_ok = 1, stop_req = 0, di_run = 0, panel_start = 0, panel_stop = 0;
  logic link_start = 0, link_stop = 0, instant_trip_on_mains_loss = 0, auto_restart = 0, ride_through = 0;
  logic fault_ack = 0, start_req = 0, di_pulse_mode = 1, reverse_release = 1, di_start, run_cmd, reverse;
  logic ready, mains_not_ready, mains_loss, ride_active, overload_trip, di_stop;
  logic signed [15:0] sp_sections = 0, sp_link = 0, sp_panel = 0, freq_cmd, v;
  logic [6:0] restart_window = 7'h05, ride_max = 7'h05;
  logic [7:0] current_pct = 8'h64;
  supervisor_pkg::cmd_src_type cmd_src = supervisor_pkg::SRC_DIGITAL;
  supervisor_pkg::sp_src_type sp_src = supervisor_pkg::SP_SECTIONS;
  int n_errors = 0, n_compared = 0, seed = 53652, cyc = 0;
  mains_loss_overload_supervisor #(.tick_cycles(10)) mains_loss_overload_supervisor_i (.*);
  plant_side plant_side_i (.*);
  always #50 clk = ~clk; // 100 ns period
  // hang guard, far above the planned run of some 2020 cycles
  always @(posedge clk) if (++cyc == 5000) begin n_errors++; give_verdict(); end
  task chk(input logic [15:0] a, input logic [15:0] e);
    n_compared++;
    if (a !== e) begin n_errors++; $display("unexpected %0t %h %h", $time, a, e); end
  endtask
  task give_verdict;
    if (n_errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // reset, each setpoint source with both signs, then mains loss while running
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1;
    for (int k = 0; k < 6; k++) begin
      stop_req = 1;
      @(negedge clk) stop_req = 0;
      v = $random(seed) % 999 + ((k & 1) ? -1000 : 1000); // never zero, sign alternates
      sp_src = supervisor_pkg::sp_src_type'(k % 3);
      sp_sections = (k % 3 == 0) ? v : -v; // unselected sources carry the other sign
      sp_link = (k % 3 == 1) ? v : -v;
      sp_panel = (k % 3 == 2) ? v : -v;
      start_req = 1;
      @(negedge clk) start_req = 0;
      repeat (20) @(negedge clk);
      chk(reverse, v < 0);
      chk(freq_cmd, v);
    end
    instant_trip_on_mains_loss = 1;
    mains_ok = 0;
    repeat (8) @(negedge clk);
    chk(run_cmd, 0);
    chk(mains_not_ready, 1);
    chk(ready, 0);
    instant_trip_on_mains_loss = 0;
    mains_ok = 1;
    repeat (20) @(negedge clk);
    chk(ready, 1);
    current_pct = 8'hc8; // 200 %, limit 18 s of 100 cycles each
    repeat (1750) @(negedge clk);
    chk(overload_trip, 0);
    repeat (100) @(negedge clk);
    chk(overload_trip, 1);
    give_verdict();
  end
endmodule
`default_nettype wire
